/* File: inc/vadj_consts.vh */
`ifndef VADJ_CONSTS_VH
`define VADJ_CONSTS_VH

// ----------------------------------------------------------------------------
// Serial bus addressing
// ----------------------------------------------------------------------------
`define VADJ_SLAVE_ADDR      7'h44
`define VADJ_DIR_WRITE       1'b0
`define VADJ_SUB_MODE_BIT    7
`define VADJ_SUB_LAST        4'h9
`define VADJ_SUB_FIRST       4'h0

// ----------------------------------------------------------------------------
// Setting offsets
// ----------------------------------------------------------------------------
`define VADJ_OFS_CONTROL     4'h0
`define VADJ_OFS_BRIGHTNESS  4'h1
`define VADJ_OFS_CONTRAST    4'h2
`define VADJ_OFS_OVERLAY     4'h3
`define VADJ_OFS_GAIN1       4'h4
`define VADJ_OFS_GAIN2       4'h5
`define VADJ_OFS_GAIN3       4'h6
`define VADJ_OFS_BREF1       4'h7
`define VADJ_OFS_BREF2       4'h8
`define VADJ_OFS_BREF3       4'h9
`define VADJ_NUM_SETTINGS    10

// ----------------------------------------------------------------------------
// Control setting bit positions
// ----------------------------------------------------------------------------
`define VADJ_CTL_PEDESTAL    0
`define VADJ_CTL_OVL_DIS     1
`define VADJ_CTL_VID_DIS     2
`define VADJ_CTL_FB_POL      3
`define VADJ_CTL_BLANK_LO    4
`define VADJ_CTL_BLANK_HI    5

// ----------------------------------------------------------------------------
// Reset values, entry 9 down to entry 0
// ----------------------------------------------------------------------------
`define VADJ_RESET_VALS      80'h00_00_00_00_00_3f_0f_26_10_08

`endif

/* File: core/vadj_sync.v */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Two-stage synchroniser for asynchronous inputs
// ----------------------------------------------------------------------------
module vadj_sync #(
    parameter W = 1
) (
    input  wire         clk,   // sampling clock
    input  wire         rst_n, // reset, active low
    input  wire [W-1:0] d,     // asynchronous inputs
    output reg  [W-1:0] q      // synchronised inputs
);

    reg [W-1:0] meta;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= {W{1'b0}};
            q    <= {W{1'b0}};
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

/* File: core/vadj_setting_bank.v */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Active settings with a single-entry shadow for buffered writes
// ----------------------------------------------------------------------------
module vadj_setting_bank #(
    parameter N          = 10,
    parameter W          = 8,
    parameter IW         = 4,
    parameter RESET_VALS = 80'h0
) (
    input  wire           clk,      // system clock
    input  wire           rst_n,    // reset, active low
    input  wire           dir_wr,   // direct write pulse
    input  wire           buf_wr,   // buffered capture pulse
    input  wire           apply,    // blanking-edge apply pulse
    input  wire [IW-1:0]  wr_idx,   // entry index
    input  wire [W-1:0]   wr_data,  // entry data
    output wire [N*W-1:0] settings  // active settings, entry 0 in low bits
);

    reg [IW-1:0] shadow_idx;
    reg [W-1:0]  shadow_data;
    reg [W-1:0]  active [0:N-1];

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shadow_idx  <= {IW{1'b0}};
            shadow_data <= {W{1'b0}};
        end else if (buf_wr) begin
            shadow_idx  <= wr_idx;
            shadow_data <= wr_data;
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_entry
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    active[i] <= RESET_VALS[i*W +: W];
                end else if (dir_wr && wr_idx == i) begin
                    active[i] <= wr_data;
                end else if (apply && shadow_idx == i) begin
                    active[i] <= shadow_data;
                end
            end
            assign settings[i*W +: W] = active[i];
        end
    endgenerate

endmodule

/* File: core/vadj_regs.v */
// Operation
// - Buffered data applies only on blanking leading edge.
// - After applying, interface resets and accepts transfers.
// - Direct-mode writes take effect at once.
// - Answer only slave address 1000100 with write.
// - Brightness_offset sets brightness offset.
// - Video_contrast sets video contrast.
// - Overlay_contrast sets overlay contrast.
// - Subaddresses 04H-06H set channel gains.
// - Polarity 0: 07H-09H set internal references.
// - Polarity 1: 07H-09H set external references.
// - Polarity 1: two select bits choose blank level.
// - Reference choice ignores pedestal enable bit.
// - Blanking input blanks signal, brightness, optional pedestal.
// - One buffered transfer per blanking edge.
// - Subaddress MSB selects direct or buffered mode.
// - Auto-increment 00H-09H, wrapping 09H to 00H.
// - Buffered subaddresses take exactly one data byte.
// - Other subaddresses acknowledged, no operation.
`timescale 1ns/1ps
`include "vadj_consts.vh"

module vadj_regs #(
    parameter W = 8
) (
    input  wire        sys_clk,                  // system clock, 25 MHz
    input  wire        nrst,                     // asynchronous reset, active low
    input  wire        scl_in,                   // serial clock pin level
    input  wire        sda_in,                   // serial data pin level
    output reg         sda_out,                  // serial data drive value
    output reg         sda_oe_n,                 // serial data drive enable, active low
    input  wire        vblank_clamp_input,       // vertical blanking pulse
    output wire [W-1:0] brightness_offset,       // brightness setting
    output wire [W-1:0] video_contrast,          // video contrast setting
    output wire [W-1:0] overlay_contrast,        // overlay contrast setting
    output wire [W-1:0] gain_channel_one,        // channel one gain
    output wire [W-1:0] gain_channel_two,        // channel two gain
    output wire [W-1:0] gain_channel_three,      // channel three gain
    output wire [W-1:0] black_ref_channel_one,   // channel one black reference
    output wire [W-1:0] black_ref_channel_two,   // channel two black reference
    output wire [W-1:0] black_ref_channel_three, // channel three black reference
    output reg         pedestal_blank_enable,    // pedestal blanking enabled
    output reg         feedback_polarity_select, // feedback polarity
    output reg         blank_level_sel_hi,       // blank level select, upper bit
    output reg         blank_level_sel_lo,       // blank level select, lower bit
    output reg         video_disable,            // video path disabled
    output reg         overlay_disable,          // overlay path disabled
    output reg         internal_ref_enable,      // references steer internal feedback
    output reg         external_ref_enable,      // references steer external voltages
    output reg  [1:0]  blank_level,              // fixed blanking level code
    output reg         signal_blank,             // signal blanking active
    output reg         brightness_blank,         // brightness blanking active
    output reg         pedestal_blank,           // pedestal blanking active
    output reg         buffered_pending          // buffered write awaits blanking edge
);

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    reg rst_meta;
    reg rst_n;

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------------------
    wire [2:0] pins_s;
    reg        scl_d;
    reg        sda_d;
    reg        vbl_d;

    vadj_sync #(
        .W     (3)
    ) u_sync (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .d     ({vblank_clamp_input, sda_in, scl_in}),
        .q     (pins_s)
    );

    wire scl_s = pins_s[0];
    wire sda_s = pins_s[1];
    wire vbl_s = pins_s[2];

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            vbl_d <= 1'b0;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            vbl_d <= vbl_s;
        end
    end

    wire scl_rise  = scl_s & ~scl_d;
    wire scl_fall  = ~scl_s & scl_d;
    wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
    wire bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
    wire vbl_lead  = vbl_s & ~vbl_d;

    // ------------------------------------------------------------------------
    // Receiver state machine
    // ------------------------------------------------------------------------
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_RECV = 5'h02;
    localparam [4:0] ST_ACK  = 5'h04;
    localparam [4:0] ST_SKIP = 5'h08;
    localparam [4:0] ST_HOLD = 5'h10;

    localparam [1:0] KIND_ADDR = 2'h0;
    localparam [1:0] KIND_SUB  = 2'h1;
    localparam [1:0] KIND_DATA = 2'h2;

    reg [4:0]   state;
    reg [4:0]   next_state;
    reg [1:0]   kind;
    reg [1:0]   next_kind;
    reg [3:0]   bit_cnt;
    reg [3:0]   next_bit_cnt;
    reg [7:0]   shift;
    reg [7:0]   next_shift;
    reg [7:0]   sub_ptr;
    reg [7:0]   next_sub_ptr;
    reg         buf_taken;
    reg         next_buf_taken;
    reg         next_sda_oe_n;
    reg         dir_wr;
    reg         buf_wr;
    reg         apply;
    reg [3:0]   wr_idx;
    reg [W-1:0] wr_data;

    // Subaddress classification.
    wire sub_buffered = sub_ptr[`VADJ_SUB_MODE_BIT];
    wire sub_in_range = (sub_ptr[6:4] == 3'h0);
    wire sub_settable = sub_in_range && (sub_ptr[3:0] <= `VADJ_SUB_LAST);
    wire addr_match   = (shift == {`VADJ_SLAVE_ADDR, `VADJ_DIR_WRITE});

    always @* begin
        next_state     = state;
        next_kind      = kind;
        next_bit_cnt   = bit_cnt;
        next_shift     = shift;
        next_sub_ptr   = sub_ptr;
        next_buf_taken = buf_taken;
        next_sda_oe_n  = sda_oe_n;
        dir_wr         = 1'b0;
        buf_wr         = 1'b0;
        apply          = 1'b0;
        wr_idx         = sub_ptr[3:0];
        wr_data        = shift;
        case (state)
            ST_HOLD: begin
                // The bus is ignored until the pending value has been applied.
                if (vbl_lead) begin
                    apply          = 1'b1;
                    next_buf_taken = 1'b0;
                    next_sda_oe_n  = 1'b1;
                    next_state     = ST_IDLE;
                end
            end
            default: begin
                if (bus_stop) begin
                    next_sda_oe_n = 1'b1;
                    next_state    = buf_taken ? ST_HOLD : ST_IDLE;
                end else if (bus_start) begin
                    next_sda_oe_n = 1'b1;
                    next_kind     = KIND_ADDR;
                    next_bit_cnt  = 4'h0;
                    next_state    = buf_taken ? ST_SKIP : ST_RECV;
                end else begin
                    case (state)
                        ST_RECV: begin
                            if (scl_rise && bit_cnt != 4'h8) begin
                                next_shift   = {shift[6:0], sda_s};
                                next_bit_cnt = bit_cnt + 4'h1;
                            end else if (scl_fall && bit_cnt == 4'h8) begin
                                case (kind)
                                    KIND_ADDR: begin
                                        if (addr_match) begin
                                            next_sda_oe_n = 1'b0;
                                            next_kind     = KIND_SUB;
                                            next_state    = ST_ACK;
                                        end else begin
                                            next_state = ST_SKIP;
                                        end
                                    end
                                    KIND_SUB: begin
                                        next_sub_ptr  = shift;
                                        next_sda_oe_n = 1'b0;
                                        next_kind     = KIND_DATA;
                                        next_state    = ST_ACK;
                                    end
                                    default: begin
                                        if (buf_taken) begin
                                            next_state = ST_SKIP;
                                        end else begin
                                            next_sda_oe_n = 1'b0;
                                            next_state    = ST_ACK;
                                            if (sub_buffered && sub_settable) begin
                                                buf_wr         = 1'b1;
                                                next_buf_taken = 1'b1;
                                            end else if (!sub_buffered && sub_settable) begin
                                                dir_wr = 1'b1;
                                                if (sub_ptr[3:0] == `VADJ_SUB_LAST) begin
                                                    next_sub_ptr = {4'h0, `VADJ_SUB_FIRST};
                                                end else begin
                                                    next_sub_ptr = sub_ptr + 8'h01;
                                                end
                                            end
                                        end
                                    end
                                endcase
                            end
                        end
                        ST_ACK: begin
                            if (scl_fall) begin
                                next_sda_oe_n = 1'b1;
                                next_bit_cnt  = 4'h0;
                                next_state    = ST_RECV;
                            end
                        end
                        default: begin
                            next_state = state;
                        end
                    endcase
                end
            end
        endcase
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= ST_IDLE;
            kind      <= KIND_ADDR;
            bit_cnt   <= 4'h0;
            shift     <= 8'h00;
            sub_ptr   <= 8'h00;
            buf_taken <= 1'b0;
            sda_oe_n  <= 1'b1;
            sda_out   <= 1'b0;
        end else begin
            state     <= next_state;
            kind      <= next_kind;
            bit_cnt   <= next_bit_cnt;
            shift     <= next_shift;
            sub_ptr   <= next_sub_ptr;
            buf_taken <= next_buf_taken;
            sda_oe_n  <= next_sda_oe_n;
            sda_out   <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Setting storage
    // ------------------------------------------------------------------------
    wire [`VADJ_NUM_SETTINGS*W-1:0] settings;

    vadj_setting_bank #(
        .N          (`VADJ_NUM_SETTINGS),
        .W          (W),
        .IW         (4),
        .RESET_VALS (`VADJ_RESET_VALS)
    ) u_bank (
        .clk        (sys_clk),
        .rst_n      (rst_n),
        .dir_wr     (dir_wr),
        .buf_wr     (buf_wr),
        .apply      (apply),
        .wr_idx     (wr_idx),
        .wr_data    (wr_data),
        .settings   (settings)
    );

    wire [W-1:0] ctrl = settings[`VADJ_OFS_CONTROL*W +: W];

    assign brightness_offset       = settings[`VADJ_OFS_BRIGHTNESS*W +: W];
    assign video_contrast          = settings[`VADJ_OFS_CONTRAST*W +: W];
    assign overlay_contrast        = settings[`VADJ_OFS_OVERLAY*W +: W];
    assign gain_channel_one        = settings[`VADJ_OFS_GAIN1*W +: W];
    assign gain_channel_two        = settings[`VADJ_OFS_GAIN2*W +: W];
    assign gain_channel_three      = settings[`VADJ_OFS_GAIN3*W +: W];
    assign black_ref_channel_one   = settings[`VADJ_OFS_BREF1*W +: W];
    assign black_ref_channel_two   = settings[`VADJ_OFS_BREF2*W +: W];
    assign black_ref_channel_three = settings[`VADJ_OFS_BREF3*W +: W];

    // ------------------------------------------------------------------------
    // Control decode and blanking outputs
    // ------------------------------------------------------------------------
    // The reference routing and blank level look only at polarity and the
    // select bits, so toggling the pedestal bit never moves them.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pedestal_blank_enable    <= 1'b0;
            feedback_polarity_select <= 1'b0;
            blank_level_sel_hi       <= 1'b0;
            blank_level_sel_lo       <= 1'b0;
            video_disable            <= 1'b0;
            overlay_disable          <= 1'b0;
            internal_ref_enable      <= 1'b1;
            external_ref_enable      <= 1'b0;
            blank_level              <= 2'h0;
            signal_blank             <= 1'b0;
            brightness_blank         <= 1'b0;
            pedestal_blank           <= 1'b0;
            buffered_pending         <= 1'b0;
        end else begin
            pedestal_blank_enable    <= ctrl[`VADJ_CTL_PEDESTAL];
            feedback_polarity_select <= ctrl[`VADJ_CTL_FB_POL];
            blank_level_sel_hi       <= ctrl[`VADJ_CTL_BLANK_HI];
            blank_level_sel_lo       <= ctrl[`VADJ_CTL_BLANK_LO];
            video_disable            <= ctrl[`VADJ_CTL_VID_DIS];
            overlay_disable          <= ctrl[`VADJ_CTL_OVL_DIS];
            internal_ref_enable      <= ~ctrl[`VADJ_CTL_FB_POL];
            external_ref_enable      <= ctrl[`VADJ_CTL_FB_POL];
            if (ctrl[`VADJ_CTL_FB_POL]) begin
                blank_level <= {ctrl[`VADJ_CTL_BLANK_HI], ctrl[`VADJ_CTL_BLANK_LO]};
            end else begin
                blank_level <= 2'h0;
            end
            signal_blank             <= vbl_s;
            brightness_blank         <= vbl_s;
            pedestal_blank           <= vbl_s & ctrl[`VADJ_CTL_PEDESTAL];
            buffered_pending         <= (next_state == ST_HOLD);
        end
    end

endmodule

/* File: tb/vadj_regs_checker.sv */
`timescale 1ns/1ps
module vadj_regs_checker #(
    parameter W = 8
) (
    input wire         sys_clk,                  // clock
    input wire         nrst,                     // reset
    input wire         scl_in,                   // bus clock
    input wire         sda_oe_n,                 // ack drive
    input wire         vblank_clamp_input,       // blanking pin
    input wire [W-1:0] video_contrast,           // setting
    input wire         feedback_polarity_select, // polarity
    input wire         blank_level_sel_hi,       // select
    input wire         blank_level_sel_lo,       // select
    input wire         internal_ref_enable,      // ref
    input wire         external_ref_enable,      // ref
    input wire [1:0]   blank_level,              // level
    input wire         signal_blank,             // blank
    input wire         pedestal_blank,           // blank
    input wire         buffered_pending          // pending
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_ctl_steady;
        $stable({feedback_polarity_select, blank_level_sel_hi, blank_level_sel_lo})[*2];
    endsequence
    sequence s_blank_edge;
        !vblank_clamp_input ##1 vblank_clamp_input;
    endsequence
    a_blank_rise: assert property (s_blank_edge |-> ##[1:4] signal_blank)
        else $error("blanking late");
    a_ped_only: assert property (pedestal_blank |-> signal_blank)
        else $error("pedestal blank alone");
    a_ref_select: assert property (s_ctl_steady |->
        internal_ref_enable != feedback_polarity_select
        && external_ref_enable == feedback_polarity_select)
        else $error("reference select wrong");
    a_blank_level: assert property (s_ctl_steady |-> blank_level ==
        (feedback_polarity_select ? {blank_level_sel_hi, blank_level_sel_lo} : 2'b00))
        else $error("blank level wrong");
    a_ack_scl_low: assert property (!$stable(sda_oe_n) |-> !scl_in)
        else $error("data moved with clock high");
    a_no_ack_pend: assert property (buffered_pending |-> sda_oe_n)
        else $error("ack while pending");
    a_apply_lead: assert property ($fell(buffered_pending) |-> $past(vblank_clamp_input, 2))
        else $error("apply without leading edge");
    a_shadow_hold: assert property (buffered_pending ##1 buffered_pending |->
        $stable(video_contrast))
        else $error("setting moved while pending");
endmodule

/* File: tb/vadj_bus_master.sv */
`timescale 1ns/1ps
module vadj_bus_master (
    input  wire sys_clk,  // clock
    input  wire sda_wire, // resolved data line
    output reg  scl_m,    // bus clock drive
    output reg  sda_m     // data drive, 1 releases
);
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // The clock stands high between frames; a long low phase lets the slave move its ack.
    task automatic bus_start;
        tick(2);
        sda_m <= 1'b0;
        tick(4);
        scl_m <= 1'b0;
    endtask
    task automatic bus_stop;
        tick(3);
        sda_m <= 1'b0;
        tick(3);
        scl_m <= 1'b1;
        tick(3);
        sda_m <= 1'b1;
        tick(4);
    endtask
    task automatic put_byte(input logic [7:0] b, output logic nack);
        for (int i = 8; i >= 0; i--) begin
            tick(3);
            sda_m <= (i > 0) ? b[i-1] : 1'b1;
            tick(3);
            scl_m <= 1'b1;
            tick(1);
            if (i == 0)
                nack = sda_wire;
            tick(1);
            scl_m <= 1'b0;
        end
    endtask
endmodule

/* File: tb/vadj_regs_bench.sv */
`timescale 1ns/1ps
module vadj_regs_bench;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        vblank = 1'b0;
    logic        mon_on = 1'b0;
    wire         scl_m, sda_m, sda_out, sda_oe_n, pend, bblank;
    wire  [7:0]  st [1:9];
    wire  [5:0]  cb;
    wire         sda_wire = sda_m & (sda_oe_n | sda_out);
    wire  [77:0] obs = {st[1], st[2], st[3], st[4], st[5], st[6], st[7], st[8], st[9], cb};
    logic [7:0]  mdl [0:9];
    logic [7:0]  b [0:15];
    logic [77:0] prev;
    logic [77:0] expq [$];
    int unsigned seed = 25160;
    int          errors = 0;
    int          tests_run = 0;
    int          cyc = 0;

    vadj_bus_master mst (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl_m(scl_m), .sda_m(sda_m));
    vadj_regs DUT (
        .sys_clk(sys_clk), .nrst(nrst), .scl_in(scl_m), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .vblank_clamp_input(vblank),
        .brightness_offset(st[1]), .video_contrast(st[2]), .overlay_contrast(st[3]),
        .gain_channel_one(st[4]), .gain_channel_two(st[5]), .gain_channel_three(st[6]),
        .black_ref_channel_one(st[7]), .black_ref_channel_two(st[8]),
        .black_ref_channel_three(st[9]), .pedestal_blank_enable(cb[0]),
        .overlay_disable(cb[1]), .video_disable(cb[2]), .feedback_polarity_select(cb[3]),
        .blank_level_sel_lo(cb[4]), .blank_level_sel_hi(cb[5]), .internal_ref_enable(),
        .external_ref_enable(), .blank_level(), .signal_blank(), .brightness_blank(bblank),
        .pedestal_blank(), .buffered_pending(pend));

    initial forever #20 sys_clk = ~sys_clk;
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [77:0] snap();
        return {mdl[1], mdl[2], mdl[3], mdl[4], mdl[5], mdl[6], mdl[7], mdl[8], mdl[9],
                mdl[0][5:0]};
    endfunction
    task automatic check(input logic [77:0] seen, input logic [77:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic put(input int i, input logic [7:0] v);
        mdl[i] = v;
        expq.push_back(snap());
    endtask
    task automatic xfer(input int n, input logic [15:0] nack_exp);
        logic nk;
        mst.bus_start();
        for (int i = 0; i < n; i++) begin
            mst.put_byte(b[i], nk);
            check(78'(nk), 78'(nack_exp[i]));
        end
        mst.bus_stop();
    endtask

    // Every change of the settings must match the oldest noted expectation.
    always @(posedge sys_clk) begin
        if (mon_on && obs !== prev)
            check(obs, (expq.size() == 0) ? prev : expq.pop_front());
        prev <= obs;
        cyc++;
        if (cyc == 10000) begin
            errors++;
            give_verdict();
        end
    end

    initial begin
        logic [7:0] v;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (8) @(posedge sys_clk);
        mdl = '{8'h08, 8'h10, 8'h26, 8'h0f, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        #1 check(obs, snap());
        mon_on = 1'b1;
        b[0] = 8'h88;
        b[1] = 8'h00;
        for (int i = 0; i < 11; i++) begin
            v = (i == 0) ? 8'h21 : (i == 10) ? 8'h39 : rnd();
            if (v === mdl[i % 10])
                v = ~v;
            b[i + 2] = v;
            put(i % 10, v);
        end
        xfer(13, 16'h0000);
        for (int k = 0; k < 5; k++) begin
            b[0] = (k < 3) ? 8'h88 : (k == 3) ? 8'h8a : 8'h89;
            b[1] = (k == 0) ? 8'h0c : (k == 1) ? 8'h40 : 8'h8c;
            b[2] = rnd();
            xfer(3, (k < 3) ? 16'h0000 : 16'h0007);
        end
        #1 check(78'(pend), 78'h0);
        vblank <= 1'b1;
        mst.tick(20);
        v = ~mdl[2];
        b[0] = 8'h88;
        b[1] = 8'h82;
        b[2] = v;
        xfer(3, 16'h0000);
        #1 check(78'(pend), 78'h1);
        b[1] = 8'h01;
        xfer(3, 16'h0007);
        vblank <= 1'b0;
        mst.tick(20);
        #1 check(78'(pend), 78'h1);
        check(78'(bblank), 78'h0);
        put(2, v);
        vblank <= 1'b1;
        mst.tick(20);
        #1 check(78'(pend), 78'h0);
        check(78'(bblank), 78'h1);
        vblank <= 1'b0;
        mst.tick(20);
        b[1] = 8'h83;
        b[2] = ~mdl[3];
        b[3] = rnd();
        xfer(4, 16'h0008);
        put(3, b[2]);
        vblank <= 1'b1;
        mst.tick(20);
        vblank <= 1'b0;
        b[1] = 8'h01;
        b[2] = ~mdl[1];
        put(1, b[2]);
        xfer(3, 16'h0000);
        mst.tick(10);
        check(78'(expq.size()), 78'h0);
        give_verdict();
    end
endmodule

bind vadj_regs vadj_regs_checker #(.W(W)) chk (
    .sys_clk, .nrst, .scl_in, .sda_oe_n, .vblank_clamp_input, .video_contrast,
    .feedback_polarity_select, .blank_level_sel_hi, .blank_level_sel_lo,
    .internal_ref_enable, .external_ref_enable, .blank_level, .signal_blank,
    .pedestal_blank, .buffered_pending);
